// >>> core/sos_seq.sv
// servo-off stop sequencer: deceleration, post-stop, brake timing
//
// Contract
// - sequence setting 0..9 picks stop behaviour
// - off: force position control, halt command generation
// - 0/4: dynamic brake both phases, clear deviation
// - 1/5: coast, then dynamic brake, clear deviation
// - 2/6: dynamic brake, then free, clear deviation
// - 3/7: coast, then free, clear deviation
// - 8: emergency stop, then dynamic brake
// - 9: emergency stop, then free
// - clearing copies feedback into command position
// - estop torque setting; zero means normal limit
// - below 30 r/min enter post-stop, stay
// - alarm while off hands over to alarm sequence
// - main power off hands over to power sequence
// - no dynamic brake fitted: free run instead
// - alarm estop time ignored in servo-off stop
// - slow stop bits replace emergency stop
// - standstill off: brake after standstill time
// - running off: brake at time or speed
// - servo-on only once motor has stopped
// - on status only echoes received command
`timescale 1ns/1ps
`default_nettype none
module sos_seq #(
  parameter int CYC_MS = sos_pkg::CYC_PER_MS, // cycles per millisecond
  parameter bit HAS_DB = 1'b1 // dynamic brake fitted
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // host commands, same clock domain
  input wire logic servo_on_cmd_in,
  // drive state
  input wire logic alarm_in,
  input wire logic main_power_off_in,
  input wire logic [sos_pkg::SPD_W-1:0] motor_speed_in,
  input wire logic [sos_pkg::POS_W-1:0] feedback_pos_in,
  // settings
  input wire sos_pkg::sos_cfg_t cfg_in,
  // servo state
  output logic servo_on_status_out,
  output logic servo_active_out,
  output logic post_stop_out,
  output logic seq_handoff_out,
  // stop actions
  output logic dynamic_brake_out,
  output logic estop_active_out,
  output logic slow_stop_out,
  output logic [sos_pkg::TRQ_W-1:0] torque_limit_out,
  output logic mech_brake_out,
  // position control
  output logic force_pos_ctrl_out,
  output logic cmd_gen_halt_out,
  output logic dev_clear_out,
  output logic [sos_pkg::POS_W-1:0] cmd_pos_out
);
  import sos_pkg::*;

  sos_state_t state; // sequencer phase
  sos_state_t next_state;
  logic [SEQ_W-1:0] seq; // setting latched at servo-off
  logic stopped; // speed below the stop threshold
  logic slow_en; // slow stop replaces emergency stop
  logic [31:0] tick_cnt; // millisecond prescaler
  logic ms_tick;
  logic [MS_W-1:0] brake_ms; // elapsed ms since servo-off
  logic brake_run; // off taken with motor running
  logic brake_pending; // brake timing in progress

  assign stopped = motor_speed_in < STOP_SPEED_RPM;
  assign slow_en = cfg_in.function_expansion_cfg[SLOW_BIT_HI] &
                   cfg_in.function_expansion_cfg[SLOW_BIT_LO];

  // dynamic brake decode per setting and phase
  function automatic logic db_for(input logic [SEQ_W-1:0] s,
                                  input logic post);
    logic r;
    r = 1'b0;
    if (!post) begin
      r = (s == 4'h0) || (s == 4'h4) || (s == 4'h2) || (s == 4'h6);
    end else begin
      r = (s == 4'h0) || (s == 4'h4) || (s == 4'h1) || (s == 4'h5) ||
          (s == SEQ_ESTOP_DB);
    end
    return r & HAS_DB;
  endfunction : db_for

  // emergency stop is used by the two top settings only
  function automatic logic is_estop(input logic [SEQ_W-1:0] s);
    return (s == SEQ_ESTOP_DB) || (s == SEQ_ESTOP_FREE);
  endfunction : is_estop

  // phase selection, evaluated once per control cycle
  always_comb begin
    next_state = state;
    case (state)
      ST_ON: begin
        if (!servo_on_cmd_in) begin
          next_state = stopped ? ST_POST : ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (alarm_in || main_power_off_in) begin
          next_state = ST_HANDOFF;
        end else if (stopped) begin
          next_state = ST_POST;
        end
      end
      ST_POST: begin
        // post-stop is left only by handover or by servo-on
        if (alarm_in || main_power_off_in) begin
          next_state = ST_HANDOFF;
        end else if (servo_on_cmd_in && stopped) begin
          next_state = ST_ON;
        end
      end
      ST_HANDOFF: begin
        // other sequences own the stop until both causes clear and the motor has stopped
        if (!alarm_in && !main_power_off_in && stopped) begin
          next_state = ST_POST;
        end
      end
      default: next_state = ST_POST;
    endcase
  end

  // state register; reset assumes servo-off at standstill
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_POST;
    end else begin
      state <= next_state;
    end
  end

  // latch the sequence setting when servo-off is accepted
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq <= 4'h0;
    end else if (state == ST_ON && next_state != ST_ON) begin
      // out-of-range settings fall back to setting 0
      seq <= (cfg_in.servo_off_sequence_sel > SEQ_MAX) ? 4'h0 :
             cfg_in.servo_off_sequence_sel;
    end
  end

  // millisecond tick, held at zero while on so brake ms are whole ones
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end else if (state == ST_ON || tick_cnt >= 32'(CYC_MS - 1)) begin
      tick_cnt <= 32'h0000_0000;
      ms_tick <= (state != ST_ON);
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      ms_tick <= 1'b0;
    end
  end

  // mechanical brake timing from the servo-off moment
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      brake_ms <= MS_RST;
      brake_run <= 1'b0;
      brake_pending <= 1'b0;
      mech_brake_out <= 1'b1;
    end else if (next_state == ST_ON) begin
      // energized: brake released
      brake_ms <= MS_RST;
      brake_pending <= 1'b0;
      mech_brake_out <= 1'b0;
    end else if (state == ST_ON) begin
      // servo-off accepted: pick the timing by motor motion
      brake_ms <= MS_RST;
      brake_run <= !stopped;
      brake_pending <= 1'b1;
      mech_brake_out <= 1'b0;
    end else if (brake_pending) begin
      if (brake_run) begin
        // whichever of time or speed comes first
        if (brake_ms >= cfg_in.brake_time_running ||
            motor_speed_in < cfg_in.brake_release_speed) begin
          brake_pending <= 1'b0;
          mech_brake_out <= 1'b1;
        end
      end else if (brake_ms >= cfg_in.brake_time_standstill) begin
        brake_pending <= 1'b0;
        mech_brake_out <= 1'b1;
      end
      if (ms_tick && brake_ms != {MS_W{1'b1}}) begin
        brake_ms <= brake_ms + 15'h0001;
      end
    end
  end

  // stop actions follow the coming phase so outputs match state
  // the alarm estop time setting has no input here at all
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      servo_active_out <= 1'b0;
      post_stop_out <= 1'b1;
      seq_handoff_out <= 1'b0;
      dynamic_brake_out <= HAS_DB;
      estop_active_out <= 1'b0;
      slow_stop_out <= 1'b0;
      force_pos_ctrl_out <= 1'b1;
      cmd_gen_halt_out <= 1'b1;
      dev_clear_out <= 1'b1;
      torque_limit_out <= TRQ_RST;
    end else begin
      servo_active_out <= 1'b0;
      post_stop_out <= 1'b0;
      seq_handoff_out <= 1'b0;
      dynamic_brake_out <= 1'b0;
      estop_active_out <= 1'b0;
      slow_stop_out <= 1'b0;
      force_pos_ctrl_out <= 1'b1;
      cmd_gen_halt_out <= 1'b1;
      dev_clear_out <= 1'b1;
      torque_limit_out <= cfg_in.normal_torque_limit;
      case (next_state)
        ST_ON: begin
          servo_active_out <= 1'b1;
          force_pos_ctrl_out <= 1'b0;
          cmd_gen_halt_out <= 1'b0;
          dev_clear_out <= 1'b0;
        end
        ST_DECEL: begin
          // the setting latches this same edge when off is taken
          if (is_estop(state == ST_ON ?
                       cfg_in.servo_off_sequence_sel : seq)) begin
            servo_active_out <= 1'b1; // controlled stop, energized
            estop_active_out <= !slow_en;
            slow_stop_out <= slow_en;
            if (!slow_en && cfg_in.estop_torque_limit != TRQ_ZERO) begin
              torque_limit_out <= cfg_in.estop_torque_limit;
            end
          end else begin
            dynamic_brake_out <= db_for(state == ST_ON ?
              cfg_in.servo_off_sequence_sel : seq, 1'b0);
          end
        end
        ST_POST: begin
          post_stop_out <= 1'b1;
          dynamic_brake_out <= db_for(state == ST_ON ?
            cfg_in.servo_off_sequence_sel : seq, 1'b1);
        end
        ST_HANDOFF: begin
          seq_handoff_out <= 1'b1;
          dev_clear_out <= 1'b0;
        end
        default: post_stop_out <= 1'b1;
      endcase
    end
  end

  // status echoes the received command, not readiness
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      servo_on_status_out <= 1'b0;
    end else begin
      servo_on_status_out <= servo_on_cmd_in;
    end
  end

  // command position tracks feedback while deviation is cleared
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_pos_out <= POS_RST;
    end else if (next_state == ST_POST || next_state == ST_DECEL) begin
      cmd_pos_out <= feedback_pos_in;
    end
  end

  // checks
  sequence seq_off_taken;
    state == ST_ON && !servo_on_cmd_in;
  endsequence
  sequence seq_off_running;
    seq_off_taken ##0 !stopped;
  endsequence

  chk_decel_exit: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state == ST_DECEL && stopped && !alarm_in && !main_power_off_in
    |=> state == ST_POST && post_stop_out)
    else $error("deceleration did not end below stop speed");
  chk_post_holds: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state == ST_POST && !servo_on_cmd_in && !alarm_in &&
    !main_power_off_in |=> state == ST_POST)
    else $error("post-stop left without cause");
  chk_on_stopped: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state == ST_ON && $past(state) != ST_ON |-> $past(stopped))
    else $error("servo-on entered while moving");
  chk_no_db: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    !HAS_DB |-> !dynamic_brake_out)
    else $error("dynamic brake driven without one fitted");
  chk_off_forced: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state != ST_ON |-> force_pos_ctrl_out && cmd_gen_halt_out)
    else $error("position control not forced while off");
  chk_cmd_follow: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    dev_clear_out |-> cmd_pos_out == $past(feedback_pos_in))
    else $error("command position not following feedback");
  chk_estop_trq: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    estop_active_out |-> torque_limit_out ==
    ($past(cfg_in.estop_torque_limit) == TRQ_ZERO ?
     $past(cfg_in.normal_torque_limit) : $past(cfg_in.estop_torque_limit)))
    else $error("emergency stop torque limit wrong");
  chk_seq_latch: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    state != ST_ON && $past(state) != ST_ON |-> $stable(seq))
    else $error("sequence setting changed while off");
  chk_alarm_hand: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    (state == ST_DECEL || state == ST_POST) && alarm_in
    |=> state == ST_HANDOFF && seq_handoff_out)
    else $error("alarm during servo-off not handed over");
  chk_run_brake: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    seq_off_running ##1 (state != ST_ON &&
      motor_speed_in < cfg_in.brake_release_speed)
    |=> mech_brake_out)
    else $error("running brake not engaged at release speed");
  chk_status_echo: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    ##1 servo_on_status_out == $past(servo_on_cmd_in))
    else $error("servo-on status does not echo command");
endmodule : sos_seq
`default_nettype wire

// >>> dv/sos_host_model.sv
// host controller model that issues servo commands to the sequencer
`timescale 1ns/1ps
`default_nettype none
module sos_host_model #(
  parameter int HOLD_CYC = 40 // normal command hold after off, scaled 4 ms
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // bench request
  input wire logic want_on_in,
  // drive side
  input wire logic servo_active_in,
  output logic servo_on_cmd_out,
  output logic normal_cmd_out,
  output logic motion_ok_out
);
  logic [15:0] hold_cnt; // cycles of normal commands left after off

  // the command level follows the request with no delay
  assign servo_on_cmd_out = want_on_in;

  // keep normal commands flowing after off so the stop uses estop torque
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_cnt <= 16'h0000;
    end else if (want_on_in) begin
      hold_cnt <= HOLD_CYC[15:0];
    end else if (hold_cnt != 16'h0000) begin
      hold_cnt <= hold_cnt - 16'h0001;
    end
  end
  assign normal_cmd_out = want_on_in || (hold_cnt != 16'h0000);

  // motion waits for real energizing; the status echo is not trusted
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      motion_ok_out <= 1'b0;
    end else begin
      motion_ok_out <= want_on_in && servo_active_in;
    end
  end
endmodule : sos_host_model
`default_nettype wire

// >>> dv/tb_sos_seq.sv
// self-checking testbench of the servo-off stop sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_sos_seq;
  import sos_pkg::*;
  logic sys_clk_in, rst_n_in, want_on, servo_on_cmd, alarm, pwr_off;
  logic [SPD_W-1:0] speed; // motor speed seen by the drive
  logic [POS_W-1:0] fb; // feedback position
  sos_cfg_t cfg;
  logic on_sts, active, post, handoff, db, estop, slow, mbrake;
  logic db_nodb; // dynamic brake of the variant without one fitted
  logic force_pc, halt, clr;
  logic [TRQ_W-1:0] trq;
  logic [POS_W-1:0] cmd_pos;
  int miscompares, comparisons, n;
  // dynamic brake per setting: deceleration and post-stop columns
  logic [9:0] dec_db = 10'h055;
  logic [9:0] post_db = 10'h133;

  sos_host_model u_host (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .want_on_in(want_on), .servo_active_in(active),
    .servo_on_cmd_out(servo_on_cmd), .normal_cmd_out(), .motion_ok_out());

  // short millisecond keeps brake timers inside the run
  sos_seq #(.CYC_MS(10), .HAS_DB(1'b1)) u_dut (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .servo_on_cmd_in(servo_on_cmd), .alarm_in(alarm),
    .main_power_off_in(pwr_off), .motor_speed_in(speed),
    .feedback_pos_in(fb), .cfg_in(cfg), .servo_on_status_out(on_sts),
    .servo_active_out(active), .post_stop_out(post),
    .seq_handoff_out(handoff), .dynamic_brake_out(db),
    .estop_active_out(estop), .slow_stop_out(slow), .torque_limit_out(trq),
    .mech_brake_out(mbrake), .force_pos_ctrl_out(force_pc),
    .cmd_gen_halt_out(halt), .dev_clear_out(clr), .cmd_pos_out(cmd_pos));

  // same stimulus into a variant that has no dynamic brake
  sos_seq #(.CYC_MS(10), .HAS_DB(1'b0)) u_nodb (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .servo_on_cmd_in(servo_on_cmd), .alarm_in(alarm),
    .main_power_off_in(pwr_off), .motor_speed_in(speed),
    .feedback_pos_in(fb), .cfg_in(cfg), .servo_on_status_out(),
    .servo_active_out(), .post_stop_out(), .seq_handoff_out(),
    .dynamic_brake_out(db_nodb), .estop_active_out(), .slow_stop_out(),
    .torque_limit_out(), .mech_brake_out(), .force_pos_ctrl_out(),
    .cmd_gen_halt_out(), .dev_clear_out(), .cmd_pos_out());

  // 100 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // wait edges, then let their updates settle
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask : tick

  // new speed at an edge, outputs sampled one edge later
  task automatic spd(input logic [SPD_W-1:0] v);
    @(posedge sys_clk_in);
    speed <= v;
    tick(1);
  endtask : spd

  // servo on from standstill with a chosen setting, then spin up
  task automatic go_on(input logic [3:0] s, input logic [15:0] v);
    @(posedge sys_clk_in);
    cfg.servo_off_sequence_sel <= s;
    want_on <= 1'b1;
    speed <= 16'h0000;
    tick(2);
    check(active, 1);
    check(clr, 0);
    check(mbrake, 0);
    spd(v);
  endtask : go_on

  task automatic go_off(input logic [POS_W-1:0] p);
    @(posedge sys_clk_in);
    want_on <= 1'b0;
    fb <= p;
    tick(1);
  endtask : go_off

  task automatic end_of_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  initial begin
    miscompares = 0;
    comparisons = 0;
    rst_n_in = 1'b0;
    want_on = 1'b0;
    alarm = 1'b0;
    pwr_off = 1'b0;
    speed = 16'h0000;
    fb = 32'h0000_0000;
    cfg = '0;
    cfg.estop_torque_limit = 10'h0C8;
    cfg.normal_torque_limit = 10'h12C;
    cfg.brake_time_standstill = 15'h0003;
    cfg.brake_time_running = 15'h0064;
    cfg.brake_release_speed = 16'h00C8;
    tick(10);
    check({post, mbrake, clr, db, active}, 5'h1E);
    @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    // every setting: decel column, running brake, post column, latch
    for (int s = 0; s <= 9; s++) begin
      @(posedge sys_clk_in);
      cfg.estop_torque_limit <= (s == 9) ? TRQ_ZERO : 10'h0C8;
      go_on(s[3:0], 16'h01F4);
      go_off(32'h0000_1000 + s);
      check(post, 0);
      check({force_pc, halt, clr}, 3'h7);
      check(db, dec_db[s]);
      check(db_nodb, 0);
      check(estop, s >= 8);
      if (s >= 8) check(trq, (s == 8) ? 10'h0C8 : 10'h12C);
      check(mbrake, 0);
      tick(1);
      check(cmd_pos, 32'h0000_1000 + s);
      spd(16'h0096);
      check(mbrake, 1);
      spd(16'h000A);
      check(post, 1);
      check(db, post_db[s]);
      check(db_nodb, 0);
      check({clr, estop}, 2'h2);
      spd(16'h01F4);
      check(post, 1);
      spd(16'h0000);
    end
    // servo-on during deceleration waits for the stop
    go_on(4'h0, 16'h01F4);
    go_off(32'h0000_2000);
    @(posedge sys_clk_in);
    want_on <= 1'b1;
    tick(3);
    check(active, 0);
    check(on_sts, 1);
    spd(16'h000A);
    tick(1);
    check(active, 1);
    // slow stop bits replace the emergency stop
    @(posedge sys_clk_in);
    cfg.function_expansion_cfg <= 16'h8400;
    go_on(4'h8, 16'h01F4);
    go_off(32'h0000_3000);
    check({slow, estop}, 2'h2);
    spd(16'h0000);
    @(posedge sys_clk_in);
    cfg.function_expansion_cfg <= 16'h0000;
    // running off, speed under the release speed one cycle later
    go_on(4'h1, 16'h01F4);
    @(posedge sys_clk_in);
    want_on <= 1'b0;
    @(posedge sys_clk_in);
    speed <= 16'h0096;
    tick(0);
    check(mbrake, 0);
    tick(1);
    check(mbrake, 1);
    spd(16'h0000);
    // standstill off: brake after the standstill time, bounded wait
    go_on(4'h3, 16'h0000);
    go_off(32'h0000_4000);
    n = 0;
    while (mbrake !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    check(n >= 28 && n <= 34, 1);
    // alarm, then power loss, during deceleration hand the stop over
    for (int k = 0; k < 2; k++) begin
      go_on(4'h0, 16'h01F4);
      go_off(32'h0000_5000);
      @(posedge sys_clk_in);
      alarm <= (k == 0);
      pwr_off <= (k == 1);
      tick(1);
      check({handoff, clr}, 2'h2);
      @(posedge sys_clk_in);
      alarm <= 1'b0;
      pwr_off <= 1'b0;
      speed <= 16'h0000;
      tick(2);
      check({handoff, post}, 2'h1);
    end
    end_of_test();
  end
endmodule : tb_sos_seq
`default_nettype wire

// >>> shared/sos_pkg.sv
// shared constants and carriers of the servo-off stop sequencer
package sos_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  // speed below which the motor counts as stopped, r/min
  localparam logic [15:0] STOP_SPEED_RPM = 16'h001E;
  // sequence setting range, 0 to 9
  localparam logic [3:0] SEQ_MAX = 4'h9;
  localparam logic [3:0] SEQ_ESTOP_DB = 4'h8;
  localparam logic [3:0] SEQ_ESTOP_FREE = 4'h9;
  // slow stop enable bits in the function expansion word
  localparam int SLOW_BIT_HI = 15;
  localparam int SLOW_BIT_LO = 10;
  // field widths
  localparam int SEQ_W = 4;
  localparam int TRQ_W = 10;
  localparam int SPD_W = 16;
  localparam int POS_W = 32;
  localparam int MS_W = 15;
  // reset values
  localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000;
  localparam logic [MS_W-1:0] MS_RST = 15'h0000;
  localparam logic [TRQ_W-1:0] TRQ_RST = 10'h000;
  localparam logic [TRQ_W-1:0] TRQ_ZERO = 10'h000;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_ON = 4'b0001,
    ST_DECEL = 4'b0010,
    ST_POST = 4'b0100,
    ST_HANDOFF = 4'b1000
  } sos_state_t;

  // configuration settings as one carrier
  typedef struct packed {
    logic [SEQ_W-1:0] servo_off_sequence_sel;
    logic [TRQ_W-1:0] estop_torque_limit;
    logic [TRQ_W-1:0] normal_torque_limit;
    logic [MS_W-1:0] brake_time_standstill;
    logic [MS_W-1:0] brake_time_running;
    logic [SPD_W-1:0] brake_release_speed;
    logic [15:0] function_expansion_cfg;
  } sos_cfg_t;
endpackage : sos_pkg
